// >>> core/cwd_pkg.sv
// package for the cpu watchdog timer: offsets, reset values, field positions
package cwd_pkg;
	localparam logic [7:0] CWD_CTRL_ADDR = 8'h39;
	localparam logic [7:0] CWD_HALF_RELOAD = 8'hFF;
	localparam int CWD_SRC_SEL_BIT = 7;
	localparam int CWD_STOP_FN_BIT = 6;
	localparam logic [3:0] CWD_DIV16_LAST = 4'hF;
	localparam logic CWD_SRC_SEL_RST = 1'b0;
	localparam logic CWD_STOP_FN_RST = 1'b0;
	localparam logic CWD_USE_ONCHIP_RST = 1'b1;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cwd_bus_s;

	typedef struct packed {
		logic wait_mode;
		logic stop_mode;
		logic osc_stable;
		logic stop_instruction;
	} cwd_mode_s;

	typedef enum logic [2:0] {
		CWD_IDLE = 3'b001,
		CWD_RUN = 3'b010,
		CWD_HALT = 3'b100
	} cwd_state_e;
endpackage

// >>> core/cwd_top.sv
// cpu watchdog timer: 16-bit down counter with stop-instruction option
//
// Function
// - counter keeps counting during wait mode
// - counter holds value in stop mode
// - counting resumes during oscillation stabilizing
// - stop function bit accepts one write
// - main oscillator clock source when selected
// - on-chip oscillator source when selected
// - on-chip oscillator source after reset; here the source still follows cpu_clk_sel_main
// - stopped until control register first written
// - reload FF both halves; high underflow resets
// - bit7 selects high half count source
// - stop instruction enters stop or resets
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module cwd_top
	import cwd_pkg::*;
(
	// clock, reset, enable
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	// register port
	input wire cwd_bus_s bus,
	output logic [7:0] rdata,
	// clock system: raw count ticks (pins) and cpu clock selection
	input wire logic main_osc_tick,
	input wire logic onchip_osc_tick,
	input wire logic cpu_clk_sel_main,
	// mode controller
	input wire cwd_mode_s mode,
	// results
	output logic internal_reset,
	output logic enter_stop
);
	logic [1:0] main_sync, onchip_sync;
	logic main_prev, onchip_prev;
	logic [7:0] wdt_high, wdt_low, next_high, next_low;
	logic [3:0] div16, next_div16;
	logic src_sel, next_src_sel;
	logic stop_fn, next_stop_fn;
	logic stop_fn_written, next_stop_fn_written;
	cwd_state_e state, next_state;
	logic [7:0] next_rdata;
	logic next_ireset, next_enter_stop;
	logic ctrl_wr, main_edge, onchip_edge, count_tick, low_uf, high_step;

	assign ctrl_wr = bus.wr && (bus.addr == CWD_CTRL_ADDR);
	assign main_edge = main_sync[1] && !main_prev;
	assign onchip_edge = onchip_sync[1] && !onchip_prev;
	// source follows cpu clock selection; reset does not force the on-chip source
	assign count_tick = cpu_clk_sel_main ? main_edge : onchip_edge;
	assign low_uf = count_tick && (wdt_low == 8'h00);

	always_comb begin
		next_state = state;
		next_high = wdt_high;
		next_low = wdt_low;
		next_div16 = div16;
		next_src_sel = src_sel;
		next_stop_fn = stop_fn;
		next_stop_fn_written = stop_fn_written;
		next_ireset = 1'b0;
		next_enter_stop = 1'b0;
		high_step = 1'b0;
		next_rdata = 8'h00;
		if (bus.rd && bus.addr == CWD_CTRL_ADDR) begin
			next_rdata = {src_sel, stop_fn, wdt_high[7:2]};
		end
		if (state != CWD_IDLE) begin
			// hold in stop; count in wait and during stabilizing
			if (mode.stop_mode && !mode.osc_stable) begin
				next_state = CWD_HALT;
			end else begin
				next_state = CWD_RUN;
				if (count_tick) begin
					next_low = wdt_low - 8'h01;
					next_div16 = div16 + 4'h1;
				end
				high_step = src_sel ? (count_tick && div16 == CWD_DIV16_LAST) : low_uf;
				if (high_step) begin
					next_high = wdt_high - 8'h01;
					if (wdt_high == 8'h00) begin
						next_ireset = 1'b1;
					end
				end
			end
		end
		if (mode.stop_instruction) begin
			if (stop_fn) begin
				next_ireset = 1'b1;
			end else begin
				next_enter_stop = 1'b1;
			end
		end
		if (ctrl_wr) begin
			// any write reloads and starts; caller should write before stop
			next_state = CWD_RUN;
			next_high = CWD_HALF_RELOAD;
			next_low = CWD_HALF_RELOAD;
			next_div16 = 4'h0;
			next_src_sel = bus.wdata[CWD_SRC_SEL_BIT];
			if (!stop_fn_written) begin
				next_stop_fn = bus.wdata[CWD_STOP_FN_BIT];
				next_stop_fn_written = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			main_sync <= 2'b00;
			onchip_sync <= 2'b00;
			main_prev <= 1'b0;
			onchip_prev <= 1'b0;
			state <= CWD_IDLE;
			wdt_high <= CWD_HALF_RELOAD;
			wdt_low <= CWD_HALF_RELOAD;
			div16 <= 4'h0;
			src_sel <= CWD_SRC_SEL_RST;
			stop_fn <= CWD_STOP_FN_RST;
			stop_fn_written <= 1'b0;
			rdata <= 8'h00;
			internal_reset <= 1'b0;
			enter_stop <= 1'b0;
		end else if (clk_en) begin
			main_sync <= {main_sync[0], main_osc_tick};
			onchip_sync <= {onchip_sync[0], onchip_osc_tick};
			main_prev <= main_sync[1];
			onchip_prev <= onchip_sync[1];
			state <= next_state;
			wdt_high <= next_high;
			wdt_low <= next_low;
			div16 <= next_div16;
			src_sel <= next_src_sel;
			stop_fn <= next_stop_fn;
			stop_fn_written <= next_stop_fn_written;
			rdata <= next_rdata;
			internal_reset <= next_ireset;
			enter_stop <= next_enter_stop;
		end
	end

	a_reload_on_write: assert property (@(posedge mclk) disable iff (reset)
		clk_en && ctrl_wr |=> wdt_high == 8'hFF && wdt_low == 8'hFF)
		else $error("write did not reload counter");
	a_idle_holds: assert property (@(posedge mclk) disable iff (reset)
		state == CWD_IDLE && !ctrl_wr |=> $stable(wdt_low))
		else $error("counter moved before first write");
	a_stop_holds: assert property (@(posedge mclk) disable iff (reset)
		clk_en && state != CWD_IDLE && mode.stop_mode && !mode.osc_stable && !ctrl_wr
		|=> $stable(wdt_low) && $stable(wdt_high))
		else $error("counter moved in stop mode");
	a_wait_counts: assert property (@(posedge mclk) disable iff (reset)
		clk_en && state != CWD_IDLE && mode.wait_mode && !mode.stop_mode && count_tick
		&& !ctrl_wr |=> wdt_low == $past(wdt_low) - 8'h01)
		else $error("counter idle in wait mode");
	a_stab_counts: assert property (@(posedge mclk) disable iff (reset)
		clk_en && state != CWD_IDLE && mode.stop_mode && mode.osc_stable && count_tick
		&& !ctrl_wr |=> wdt_low == $past(wdt_low) - 8'h01)
		else $error("counter idle while stabilizing");
	a_stop_fn_once: assert property (@(posedge mclk) disable iff (reset)
		stop_fn_written |=> $stable(stop_fn))
		else $error("stop function bit rewritten");
	a_src_follows: assert property (@(posedge mclk) disable iff (reset)
		count_tick == (cpu_clk_sel_main ? main_edge : onchip_edge))
		else $error("wrong count source");
	a_underflow_rst: assert property (@(posedge mclk) disable iff (reset)
		clk_en && high_step && wdt_high == 8'h00 |=> internal_reset)
		else $error("no reset on high underflow");
	a_stop_instr: assert property (@(posedge mclk) disable iff (reset)
		clk_en && mode.stop_instruction |=> (stop_fn ? internal_reset : enter_stop)
		|| $past(stop_fn) != stop_fn)
		else $error("stop instruction misrouted");
	a_hi_src: assert property (@(posedge mclk) disable iff (reset)
		clk_en && state == CWD_RUN && !src_sel && !low_uf && !ctrl_wr
		&& !(mode.stop_mode && !mode.osc_stable) |=> $stable(wdt_high))
		else $error("high half stepped without low underflow");

	// idle must hold the whole counter, not just the low half
	a_idle_high: assert property (@(posedge mclk) disable iff (reset)
		state == CWD_IDLE && !ctrl_wr |=> $stable(wdt_high))
		else $error("high half moved before first write");

	// the first write of any value must start the count-down
	a_first_start: assert property (@(posedge mclk) disable iff (reset)
		clk_en && state == CWD_IDLE && ctrl_wr |=> state == CWD_RUN)
		else $error("first write did not start counting");

	// stop with the oscillator down parks the state machine
	a_halt_state: assert property (@(posedge mclk) disable iff (reset)
		clk_en && state != CWD_IDLE && mode.stop_mode && !mode.osc_stable && !ctrl_wr
		|=> state == CWD_HALT)
		else $error("stop mode did not halt");

	// each routing of the stop instruction is checked on its own
	a_stop_enter: assert property (@(posedge mclk) disable iff (reset)
		clk_en && mode.stop_instruction && !stop_fn |=> enter_stop)
		else $error("stop instruction did not enter stop");
	a_stop_reset: assert property (@(posedge mclk) disable iff (reset)
		clk_en && mode.stop_instruction && stop_fn |=> internal_reset)
		else $error("stop instruction did not reset");

	// divided source: high half steps on the last prescaler count
	a_div_step: assert property (@(posedge mclk) disable iff (reset)
		clk_en && state == CWD_RUN && src_sel && count_tick && div16 == CWD_DIV16_LAST
		&& !ctrl_wr && !(mode.stop_mode && !mode.osc_stable)
		|=> wdt_high == $past(wdt_high) - 8'h01)
		else $error("high half missed divided step");

	// a low enable must freeze the counter completely
	a_en_freeze: assert property (@(posedge mclk) disable iff (reset)
		!clk_en |=> $stable(wdt_low) && $stable(wdt_high))
		else $error("counter moved with enable low");

	// main scenarios: start, underflow, stop entry, halt and resume
	c_first_write: cover property (@(posedge mclk) state == CWD_IDLE ##1 state == CWD_RUN);
	c_resume: cover property (@(posedge mclk) state == CWD_HALT ##1 state == CWD_RUN);
	c_underflow: cover property (@(posedge mclk) internal_reset);
	c_stop_entry: cover property (@(posedge mclk) enter_stop);
	c_halt: cover property (@(posedge mclk) state == CWD_HALT);
endmodule // cwd_top

// >>> verif/cwd_osc_model.sv
// clock system model: main and on-chip oscillator levels for the watchdog
`timescale 1ns/1ns
module cwd_osc_model (
	// clock and run controls
	input wire logic mclk,
	input wire logic main_run,
	input wire logic chip_run,
	// oscillator levels
	output logic main_osc_tick,
	output logic onchip_osc_tick
);
	logic div = 1'b0;
	initial begin
		main_osc_tick = 1'b0;
		onchip_osc_tick = 1'b0;
	end
	// a stopped oscillator freezes its level, so it gives no edges at all
	always @(posedge mclk) begin
		div <= ~div;
		if (main_run) main_osc_tick <= ~main_osc_tick;
		if (chip_run && div) onchip_osc_tick <= ~onchip_osc_tick;
	end
endmodule // cwd_osc_model

// >>> verif/test_cpu_watchdog_timer.sv
// self-checking bench for the cpu watchdog timer
`timescale 1ns/1ns
module test_cpu_watchdog_timer;
	import cwd_pkg::*;
	logic mclk = 0, reset = 1, sel = 0, mrun = 1, crun = 1, en = 1;
	cwd_bus_s bus = '0;
	cwd_mode_s mode = '0;
	logic [7:0] rdata, rv;
	logic m_tick, c_tick, irst, estop;
	int failures = 0, n_checks = 0, cyc = 0, n;
	always #25 mclk = ~mclk;
	cwd_osc_model osc (.mclk(mclk), .main_run(mrun), .chip_run(crun),
		.main_osc_tick(m_tick), .onchip_osc_tick(c_tick));
	cwd_top dut (.mclk(mclk), .reset(reset), .clk_en(en), .bus(bus), .rdata(rdata),
		.main_osc_tick(m_tick), .onchip_osc_tick(c_tick), .cpu_clk_sel_main(sel),
		.mode(mode), .internal_reset(irst), .enter_stop(estop));
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures = failures + 1;
			end_of_test();
		end
	end
	task do_rst;
		@(posedge mclk);
		reset <= 1;
		repeat (10) @(posedge mclk);
		reset <= 0;
	endtask
	task wr(input logic [7:0] d);
		@(posedge mclk);
		bus <= '{CWD_CTRL_ADDR, d, 1'b1, 1'b0};
		@(posedge mclk);
		bus.wr <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge mclk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		bus.rd <= 0;
		#1 rv = rdata;
	endtask
	// 400 cycles give at least 64 ticks, enough to clear high bit 2
	task moved(input logic e);
		repeat (400) @(posedge mclk);
		rd(CWD_CTRL_ADDR);
		chk(rv[5:0] != 6'h3F, e);
	endtask
	task pulse;
		@(posedge mclk);
		mode.stop_instruction <= 1;
		@(posedge mclk);
		mode.stop_instruction <= 0;
		#1;
	endtask
	initial begin
		do_rst();
		rd(CWD_CTRL_ADDR);
		chk(rv, 8'h3F);
		moved(0);
		rd(8'h38);
		chk(rv, 8'h00);
		$display("reset test done");
		wr(8'h80);
		moved(1);
		crun <= 0;
		wr(8'h80);
		moved(0);
		sel <= 1;
		wr(8'h80);
		moved(1);
		mrun <= 0;
		crun <= 1;
		wr(8'h80);
		moved(0);
		$display("source test done");
		do_rst();
		sel <= 0;
		wr(8'h80);
		mode.stop_mode <= 1;
		moved(0);
		mode.osc_stable <= 1;
		moved(1);
		mode <= '0;
		wr(8'h80);
		mode.wait_mode <= 1;
		moved(1);
		mode.wait_mode <= 0;
		$display("mode test done");
		wr(8'h80);
		en <= 0;
		repeat (400) @(posedge mclk);
		en <= 1;
		rd(CWD_CTRL_ADDR);
		chk(rv[5:0], 6'h3F);
		$display("enable test done");
		do_rst();
		wr(8'h00);
		wr(8'h40);
		rd(CWD_CTRL_ADDR);
		chk(rv[6], 1'b0);
		pulse();
		chk({irst, estop}, 2'b01);
		do_rst();
		wr(8'h40);
		wr(8'h00);
		rd(CWD_CTRL_ADDR);
		chk(rv[6], 1'b1);
		pulse();
		chk({irst, estop}, 2'b10);
		$display("stop function test done");
		do_rst();
		wr(8'h80);
		n = 0;
		while (irst !== 1'b1 && n < 20000) begin
			@(posedge mclk);
			#1 n++;
		end
		chk(n > 16200 && n < 16600, 1'b1);
		$display("underflow test done");
		end_of_test();
	end
endmodule // test_cpu_watchdog_timer
